// >>> rtl/icr_pkg.sv
// Constants shared by both ends of the I2C register access link.
// Assumes a 125 MHz core clock and a 1 MHz bus.
package icr_pkg;
    // ****************************************
    // Command bytes
    // ****************************************
    localparam logic [2:0] OP_WR   = 3'h3;
    localparam logic [2:0] OP_RD   = 3'h4;
    // Positions in the assembled command word, byte 0 at the top
    localparam int         CM_OP   = 24;
    localparam int         CM_PHI  = 16;
    localparam int         CM_PLO  = 15;
    localparam int         CM_BE   = 10;
    localparam int         CM_AHI  = 8;
    localparam int         CM_ALO  = 0;
    // ****************************************
    // Bit and byte counts
    // ****************************************
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;
    localparam logic [3:0] IDX_ADR = 4'h0;
    localparam logic [3:0] IDX_C0  = 4'h1;
    localparam logic [3:0] IDX_CL  = 4'h4;
    localparam logic [3:0] IDX_D0  = 4'h5;
    localparam logic [3:0] IDX_DL  = 4'h8;
    localparam logic [3:0] IDX_MAX = 4'hF;
    // ****************************************
    // Bus timing
    // ****************************************
    localparam int         CLK_NS  = 8;
    // 1 MHz keeps one register transfer near 11k core clocks
    localparam int         QTR_NS  = 250;
    localparam int         QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [8:0] TICK_LAST = 9'(QTR_CYC - 1);
    // ****************************************
    // Controller registers (APB byte addresses)
    // ****************************************
    localparam logic [7:0] A_CMD   = 8'h00;
    localparam logic [7:0] A_WDAT  = 8'h04;
    localparam logic [7:0] A_RDAT  = 8'h08;
    localparam logic [7:0] A_STAT  = 8'h0C;
    localparam int         CF_OP   = 0;
    localparam int         CF_PORT = 3;
    localparam int         CF_BE   = 5;
    localparam int         CF_ADR  = 9;
    localparam int         CF_SAD  = 19;
    localparam int         CF_RS   = 30;
    localparam int         CF_GO   = 31;
    localparam int         SF_BUSY = 0;
    localparam int         SF_DONE = 1;
    localparam int         SF_NAK  = 2;
    localparam logic [31:0] CMD_RST = 32'h0;
    // Controller sequence steps
    localparam logic [3:0] ST_WP   = 4'hA;
    localparam logic [3:0] ST_RP1  = 4'h6;
    localparam logic [3:0] ST_RS   = 4'h7;
    localparam logic [3:0] ST_RA   = 4'h8;
    localparam logic [3:0] ST_RL   = 4'hC;
    localparam logic [3:0] ST_RP   = 4'hD;
endpackage

// >>> rtl/icr_if.sv
// Two-wire link between controller and register access slave.
// Both lines are open drain with a pull-up; level resolved here.
`timescale 1ns/1ps
`default_nettype none
interface icr_if;
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    logic s_scl_o;
    logic s_scl_oe;
    logic s_sda_o;
    logic s_sda_oe;
    logic scl;
    logic sda;
    // Wired AND with pull-up
    assign scl = ~((m_scl_oe & ~m_scl_o) | (s_scl_oe & ~s_scl_o));
    assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
    modport master (input scl, input sda, output m_scl_o,
                    output m_scl_oe, output m_sda_o, output m_sda_oe);
    modport slave  (input scl, input sda, output s_scl_o,
                    output s_scl_oe, output s_sda_o, output s_sda_oe);
endinterface
`default_nettype wire

// >>> rtl/icr_slave.sv
// Device end: I2C slave giving access to 32-bit config registers.
// Assumes a register file on the reg_* port answering with reg_ack.
`timescale 1ns/1ps
`default_nettype none
module icr_slave
    import icr_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // Slave address strap
    input  wire logic [6:0]  dev_addr,
    // Two-wire link
    icr_if.slave             bus,
    // Register file port
    output logic             reg_req,
    output logic             reg_we,
    output logic [2:0]       reg_sel,
    output logic [11:0]      reg_addr,
    output logic [3:0]       reg_be,
    output logic [31:0]      reg_wdata,
    input  wire logic        reg_ack,
    input  wire logic [31:0] reg_rdata
);
    import icr_pkg::*;

    typedef enum logic [1:0] {SL_IDLE, SL_RX, SL_TX, SL_SKIP} icr_sph_type;

    typedef struct packed {
        icr_sph_type sph;
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        logic [3:0]  cnt;
        logic [7:0]  sh;
        logic [3:0]  idx;
        logic [1:0]  rsel;
        logic        ack;
        logic        mnak;
        logic        sda_oe;
        logic [31:0] cmd;
        logic [31:0] wdat;
        logic [31:0] hold;
        logic        req;
        logic        we;
        logic [2:0]  sel;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } icr_sst_type;

    icr_sst_type q;
    icr_sst_type n;

    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic [2:0] port_hot(input logic [1:0] p);
        case (p)
            2'h0:    port_hot = 3'h1;
            2'h1:    port_hot = 3'h2;
            2'h2:    port_hot = 3'h4;
            default: port_hot = 3'h0;
        endcase
    endfunction

    function automatic logic [7:0] buf_byte(input logic [31:0] b,
                                            input logic [1:0]  s);
        case (s)
            2'h0:    buf_byte = b[31:24];
            2'h1:    buf_byte = b[23:16];
            2'h2:    buf_byte = b[15:8];
            default: buf_byte = b[7:0];
        endcase
    endfunction

    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        sda;
    logic [2:0]  op;
    logic [1:0]  port;
    logic [11:0] addr;
    logic        ok;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n     = q;
        sda   = q.sda_s[1];
        rise  = q.scl_s[1] & ~q.scl_s[2];
        fall  = ~q.scl_s[1] & q.scl_s[2];
        start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~q.sda_s[1];
        stop  = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & q.sda_s[1];
        op    = q.cmd[CM_OP +: 3];
        port  = {q.cmd[CM_PHI], q.cmd[CM_PLO]};
        addr  = {q.cmd[CM_AHI +: 2], q.cmd[CM_ALO +: 8], 2'b00};
        ok    = 1'b0;
        // Only the second and third flops of each three-flop chain feed the edge logic
        n.scl_s = {q.scl_s[1:0], bus.scl};
        n.sda_s = {q.sda_s[1:0], bus.sda};

        if (q.req && reg_ack) begin
            n.req = 1'b0;
            if (!q.we) begin
                n.hold = reg_rdata;
            end
        end

        if (stop) begin
            n.sph    = SL_IDLE;
            n.sda_oe = 1'b0;
        end else if (start) begin
            // Command kept across a repeated START
            n.sph    = SL_RX;
            n.cnt    = 4'h0;
            n.idx    = IDX_ADR;
            n.sda_oe = 1'b0;
        end else begin
            case (q.sph)
                SL_RX: begin
                    if (rise) begin
                        if (q.cnt < BIT_ACK) begin
                            n.sh  = {q.sh[6:0], sda};
                            n.cnt = q.cnt + 4'h1;
                        end else begin
                            n.cnt = BIT_END;
                        end
                    end
                    if (fall && q.cnt == BIT_ACK) begin
                        if (q.idx == IDX_ADR) begin
                            ok = (q.sh[7:1] == dev_addr);
                        end else if (q.idx <= IDX_CL) begin
                            ok    = 1'b1;
                            n.cmd = {q.cmd[23:0], q.sh};
                        end else if (q.idx <= IDX_DL) begin
                            // Data only acked under a write code; wdat shifts in under any code
                            ok     = (op == OP_WR);
                            n.wdat = {q.wdat[23:0], q.sh};
                        end else begin
                            ok = 1'b0;
                        end
                        n.ack    = ok;
                        n.sda_oe = ok;
                    end
                    if (fall && q.cnt == BIT_END) begin
                        n.sda_oe = 1'b0;
                        n.cnt    = 4'h0;
                        if (q.idx != IDX_MAX) begin
                            n.idx = q.idx + 4'h1;
                        end
                        if (!q.ack) begin
                            n.sph = SL_SKIP;
                        end else if (q.idx == IDX_ADR && q.sh[0]) begin
                            n.sph    = SL_TX;
                            n.sh     = buf_byte(q.hold, 2'h0);
                            n.sda_oe = ~q.hold[31];
                            n.rsel   = 2'h1;
                        end else if (q.idx == IDX_CL && op == OP_RD
                                     && port_hot(port) != 3'h0) begin
                            n.req  = 1'b1;
                            n.we   = 1'b0;
                            n.sel  = port_hot(port);
                            n.addr = addr;
                            n.be   = q.cmd[CM_BE +: 4];
                        end else if (q.idx == IDX_DL && op == OP_WR
                                     && port_hot(port) != 3'h0) begin
                            // Invalid code or port never gets here
                            n.req   = 1'b1;
                            n.we    = 1'b1;
                            n.sel   = port_hot(port);
                            n.addr  = addr;
                            n.be    = q.cmd[CM_BE +: 4];
                            n.wdata = q.wdat;
                        end
                    end
                end
                SL_TX: begin
                    if (rise) begin
                        if (q.cnt == BIT_ACK) begin
                            n.mnak = sda;
                            n.cnt  = BIT_END;
                        end else begin
                            n.cnt = q.cnt + 4'h1;
                        end
                    end
                    if (fall && q.cnt != 4'h0) begin
                        if (q.cnt < BIT_ACK) begin
                            n.sh     = {q.sh[6:0], 1'b0};
                            n.sda_oe = ~q.sh[6];
                        end else if (q.cnt == BIT_ACK) begin
                            n.sda_oe = 1'b0;
                        end else if (q.mnak) begin
                            n.sph = SL_SKIP;
                        end else begin
                            // Two-bit index wraps back to the top byte
                            n.sh     = buf_byte(q.hold, q.rsel);
                            n.sda_oe = ~n.sh[7];
                            n.rsel   = q.rsel + 2'h1;
                            n.cnt    = 4'h0;
                        end
                    end
                end
                default: begin
                    n.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bus.s_scl_o  = 1'b0;
    assign bus.s_scl_oe = 1'b0;
    assign bus.s_sda_o  = 1'b0;
    assign bus.s_sda_oe = q.sda_oe;
    assign reg_req      = q.req;
    assign reg_we       = q.we;
    assign reg_sel      = q.sel;
    assign reg_addr     = q.addr;
    assign reg_be       = q.be;
    assign reg_wdata    = q.wdata;
endmodule
`default_nettype wire

// >>> rtl/icr_master.sv
// Controller end: I2C master driven by software over APB.
// Assumes a slave that never stretches the clock.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module icr_master
    import icr_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Two-wire link
    icr_if.master            bus
);
    import icr_pkg::*;

    typedef enum logic [1:0] {M_IDLE, M_STA, M_BIT, M_STO} icr_mph_type;
    typedef enum logic [2:0] {K_S, K_W, K_R, K_P, K_NONE, K_END} icr_kind_type;

    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] wdat;
        logic [31:0] rdat;
        logic        busy;
        logic        done;
        logic        nak;
        logic        abt;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        icr_mph_type ph;
        logic [8:0]  tick;
        logic [1:0]  qt;
        logic [3:0]  step;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        rx;
        logic [1:0]  sda_s;
        logic        scl_oe;
        logic        sda_oe;
    } icr_mst_type;

    icr_mst_type q;
    icr_mst_type n;

    // ****************************************
    // Packet layout
    // ****************************************
    function automatic icr_kind_type kind(input logic [3:0] s,
                                          input logic rd, input logic rs);
        if (s == 4'h0) begin
            kind = K_S;
        end else if (!rd) begin
            kind = (s < ST_WP) ? K_W : (s == ST_WP) ? K_P : K_END;
        end else if (s < ST_RP1 || s == ST_RA) begin
            kind = K_W;
        end else if (s == ST_RP1) begin
            kind = rs ? K_NONE : K_P;
        end else if (s == ST_RS) begin
            kind = K_S;
        end else if (s <= ST_RL) begin
            kind = K_R;
        end else begin
            kind = (s == ST_RP) ? K_P : K_END;
        end
    endfunction

    function automatic logic [7:0] tx_byte(input logic [3:0] s,
                                           input logic rd,
                                           input logic [31:0] c,
                                           input logic [31:0] w);
        case (s)
            4'h1:    tx_byte = {c[CF_SAD +: 7], 1'b0};
            4'h2:    tx_byte = {5'h00, c[CF_OP +: 3]};
            4'h3:    tx_byte = {7'h00, c[CF_PORT + 1]};
            4'h4:    tx_byte = {c[CF_PORT], 1'b0, c[CF_BE +: 4],
                                c[CF_ADR + 8 +: 2]};
            4'h5:    tx_byte = c[CF_ADR +: 8];
            4'h6:    tx_byte = w[31:24];
            4'h7:    tx_byte = w[23:16];
            4'h8:    tx_byte = rd ? {c[CF_SAD +: 7], 1'b1} : w[15:8];
            4'h9:    tx_byte = w[7:0];
            default: tx_byte = 8'hFF;
        endcase
    endfunction

    logic         rd;
    logic         qe;
    logic [3:0]   nxt;
    icr_kind_type kn;

    always_comb begin
        n   = q;
        rd  = (q.cmd[CF_OP +: 3] == OP_RD);
        qe  = 1'b0;
        nxt = q.step + 4'h1;
        if (kind(nxt, rd, q.cmd[CF_RS]) == K_NONE) begin
            nxt = q.step + 4'h2;
        end
        kn = kind(nxt, rd, q.cmd[CF_RS]);
        n.sda_s  = {q.sda_s[0], bus.sda};
        n.pready = 1'b1;

        // ****************************************
        // APB registers
        // ****************************************
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            case (paddr)
                A_CMD:   n.prdata = q.cmd;
                A_WDAT:  n.prdata = q.wdat;
                A_RDAT:  n.prdata = q.rdat;
                A_STAT:  n.prdata = {29'h0, q.nak, q.done, q.busy};
                default: begin
                    n.prdata  = 32'h0;
                    n.pslverr = 1'b1;
                end
            endcase
        end
        if (psel && penable && q.pready && pwrite) begin
            if (paddr == A_CMD && !q.busy) begin
                n.cmd = pwdata;
                if (pwdata[CF_GO]) begin
                    n.busy = 1'b1;
                    n.nak  = 1'b0;
                    n.abt  = 1'b0;
                    n.step = 4'h0;
                    n.ph   = M_STA;
                    n.qt   = 2'h0;
                    n.tick = 9'h0;
                end
            end else if (paddr == A_WDAT && !q.busy) begin
                n.wdat = pwdata;
            end else if (paddr == A_STAT && pwdata[SF_DONE]) begin
                n.done = 1'b0;
            end
        end

        // ****************************************
        // Bit engine, four quarters per bit
        // ****************************************
        if (q.ph != M_IDLE) begin
            if (q.tick == TICK_LAST) begin
                n.tick = 9'h0;
                n.qt   = q.qt + 2'h1;
                qe     = 1'b1;
            end else begin
                n.tick = q.tick + 9'h1;
            end
        end
        if (qe) begin
            case (q.ph)
                M_STA: begin
                    // Same shape serves a first and a repeated START
                    case (q.qt)
                        2'h0:    n.sda_oe = 1'b0;
                        2'h1:    n.scl_oe = 1'b0;
                        2'h2:    n.sda_oe = 1'b1;
                        default: n.scl_oe = 1'b1;
                    endcase
                end
                M_STO: begin
                    case (q.qt)
                        2'h0:    n.sda_oe = 1'b1;
                        2'h1:    n.scl_oe = 1'b0;
                        2'h2:    n.sda_oe = 1'b0;
                        default: n.sda_oe = 1'b0;
                    endcase
                end
                M_BIT: begin
                    case (q.qt)
                        2'h0: begin
                            if (q.rx) begin
                                // Last read byte gets NAK to end data
                                n.sda_oe = (q.bitn == BIT_ACK)
                                           && (q.step != ST_RL);
                            end else begin
                                n.sda_oe = (q.bitn < BIT_ACK) && !q.sh[7];
                            end
                        end
                        2'h1: n.scl_oe = 1'b0;
                        2'h2: begin
                            if (q.bitn < BIT_ACK) begin
                                n.sh = {q.sh[6:0], q.sda_s[1]};
                            end else if (!q.rx && q.sda_s[1]) begin
                                n.nak = 1'b1;
                            end
                        end
                        default: begin
                            n.scl_oe = 1'b1;
                            n.bitn   = q.bitn + 4'h1;
                        end
                    endcase
                end
                default: begin
                    n.ph = M_IDLE;
                end
            endcase
        end

        // Step complete: abort on NAK, finish after the last step or the abort STOP, else move to the next step
        if (qe && q.qt == 2'h3 && q.ph == M_BIT && q.bitn == BIT_ACK) begin
            if (q.rx) begin
                n.rdat = {q.rdat[23:0], q.sh};
            end
        end
        if (qe && q.qt == 2'h3 && q.ph != M_IDLE
            && (q.ph != M_BIT || q.bitn == BIT_ACK)) begin
            n.bitn = 4'h0;
            if (q.ph == M_BIT && q.nak) begin
                n.ph  = M_STO;
                n.abt = 1'b1;
            end else if (kn == K_END || (q.ph == M_STO && q.abt)) begin
                n.ph   = M_IDLE;
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.step = nxt;
                n.sh   = tx_byte(nxt, rd, q.cmd, q.wdat);
                n.rx   = (kn == K_R);
                n.ph   = (kn == K_S) ? M_STA :
                         (kn == K_P) ? M_STO : M_BIT;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bus.m_scl_o  = 1'b0;
    assign bus.m_scl_oe = q.scl_oe;
    assign bus.m_sda_o  = 1'b0;
    assign bus.m_sda_oe = q.sda_oe;
    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
endmodule
`default_nettype wire

// >>> verif/icr_assertions.sv
// Checker for the two-wire link and the slave's register port.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module icr_assertions (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        scl,
    input wire logic        s_sda_oe,
    input wire logic        m_scl_oe,
    input wire logic        reg_req,
    input wire logic        reg_ack,
    input wire logic [2:0]  reg_sel,
    input wire logic [11:0] reg_addr
);
    // ****
    // Properties
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_taken; reg_req && reg_ack; endsequence
    a_addr_align: assert property (reg_req |-> reg_addr[1:0] == 2'h0)
        else $error("reg_addr not word aligned");
    a_port_onehot: assert property (reg_req |-> $onehot(reg_sel))
        else $error("reg_sel not one-hot");
    a_req_holds: assert property (reg_req && !reg_ack |=> reg_req && $stable(reg_addr))
        else $error("request dropped or changed early");
    a_req_ends: assert property (s_taken |=> !reg_req)
        else $error("request stayed after ack");
    a_req_scl_low: assert property ($rose(reg_req) |-> !scl)
        else $error("request rose with clock line high");
    a_sda_steady: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
        else $error("slave moved data while clock high");
    a_ack_scl_low: assert property ($rose(s_sda_oe) |-> !scl)
        else $error("slave pulled data with clock high");
    a_rst_idle: assert property ($fell(sys_rst) |-> !s_sda_oe && !m_scl_oe)
        else $error("lines driven after reset");
endmodule
`default_nettype wire

// >>> verif/i2c_config_register_access_tb.sv
// Bench: APB drives the controller, which talks to the slave.
// Assumes a register port that acks one cycle after each request.
`timescale 1ns/1ps
`default_nettype none
module i2c_config_register_access_tb;
    import icr_pkg::*;
    logic        mclk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        reg_req, reg_we, reg_ack, cap_we;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, reg_wdata, rd, cap_wd, reg_rdata;
    logic [2:0]  reg_sel, cap_sel;
    logic [11:0] reg_addr, cap_addr;
    logic [3:0]  reg_be, cap_be;
    int          n_fail, checks_done, n_req, cyc, m;
    icr_if bus ();
    icr_master icr_master_inst (.mclk, .sys_rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .bus(bus.master));
    icr_slave icr_slave_inst (.mclk, .sys_rst, .dev_addr(7'h38),
        .bus(bus.slave), .reg_req, .reg_we, .reg_sel, .reg_addr, .reg_be,
        .reg_wdata, .reg_ack, .reg_rdata);
    // Read data carries the address, so a stale buffer shows up
    assign reg_rdata = {20'hA5C3E, reg_addr};
    icr_assertions icr_assertions_inst (.mclk, .sys_rst, .scl(bus.scl),
        .s_sda_oe(bus.s_sda_oe), .m_scl_oe(bus.m_scl_oe), .reg_req,
        .reg_ack, .reg_sel, .reg_addr);
    // ****
    // Clock, register file, timeout
    // ****
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        reg_ack <= reg_req && !reg_ack;
        if (reg_req && reg_ack) begin
            n_req <= n_req + 1;
            {cap_we, cap_sel, cap_addr, cap_be} <= {reg_we, reg_sel, reg_addr, reg_be};
            cap_wd <= reg_wdata;
        end
        // Six transfers of at most about 12k cycles each
        if (cyc == 90000) begin
            n_fail++;
            end_sim;
        end
    end
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'h1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk) penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rd = prdata;
        psel <= 1'h0; penable <= 1'h0;
        @(posedge mclk);
    endtask
    task run(input logic [31:0] cmd, input logic [31:0] wd, input logic en);
        apb(1'h1, A_WDAT, wd);
        apb(1'h1, A_CMD, cmd);
        rd = 32'h0;
        while (rd[SF_DONE] !== 1'h1) apb(1'h0, A_STAT, 32'h0);
        chk("nak", en, rd[SF_NAK]);
        apb(1'h1, A_STAT, 32'h2);
    endtask
    task t_write;
        run({1'h1, 1'h0, 4'h0, 7'h38, 10'h02D, 4'h5, 2'h2, 3'h3},
            32'hA1B2C3D4, 1'h0);
        chk("addr", 12'h0B4, cap_addr);
        chk("sel", 3'h4, cap_sel);
        chk("be", 4'h5, cap_be);
        chk("wdata", 32'hA1B2C3D4, cap_wd);
        chk("we", 1'h1, cap_we);
        $display("write test done");
    endtask
    task t_read;
        run({1'h1, 1'h1, 4'h0, 7'h38, 10'h3FF, 4'hF, 2'h1, 3'h4}, 32'h0, 1'h0);
        chk("raddr", 12'hFFC, cap_addr);
        chk("rsel", 3'h2, cap_sel);
        chk("rwe", 1'h0, cap_we);
        apb(1'h0, A_RDAT, 32'h0);
        chk("rdata", 32'hA5C3EFFC, rd);
        $display("read test done");
    endtask
    task t_read_stop;
        run({1'h1, 1'h0, 4'h0, 7'h38, 10'h02D, 4'hF, 2'h0, 3'h4}, 32'h0, 1'h0);
        chk("saddr", 12'h0B4, cap_addr);
        chk("ssel", 3'h1, cap_sel);
        chk("swe", 1'h0, cap_we);
        apb(1'h0, A_RDAT, 32'h0);
        chk("sdata", 32'hA5C3E0B4, rd);
        $display("read after stop test done");
    endtask
    task t_nak;
        m = n_req;
        run({1'h1, 1'h0, 4'h0, 7'h39, 10'h02D, 4'hF, 2'h0, 3'h3}, 32'h0, 1'h1);
        chk("adr_reqs", 32'(m), 32'(n_req));
        run({1'h1, 1'h0, 4'h0, 7'h38, 10'h02D, 4'hF, 2'h0, 3'h5}, 32'h0, 1'h1);
        chk("op_reqs", 32'(m), 32'(n_req));
        $display("nak test done");
    endtask
    task t_bad;
        m = n_req;
        run({1'h1, 1'h0, 4'h0, 7'h38, 10'h02D, 4'hF, 2'h3, 3'h3}, 32'h0, 1'h0);
        chk("reqs", 32'(m), 32'(n_req));
        $display("bad port test done");
    endtask
    task end_sim;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        {mclk, psel, penable, pwrite, reg_ack, paddr, pwdata} = '0;
        sys_rst = 1'h1;
        {n_fail, checks_done, n_req, cyc} = '0;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'h0;
        @(posedge mclk);
        apb(1'h0, 8'h10, 32'h0);
        chk("unmapped", 1'h1, pslverr);
        t_write;
        t_read;
        t_read_stop;
        t_bad;
        t_nak;
        end_sim;
    end
endmodule
`default_nettype wire
